// file: ncs_checker.sv
// assertion checker for the command source selector
`timescale 1ns/1ps
`default_nettype none
module ncs_checker
  import ncs_pkg::*;
(
  input wire logic                   clk_sys,
  input wire logic                   reset,
  input wire logic                   clkEn,
  input wire logic                   driveStopped,
  input wire logic                   settingWrite,
  input wire logic [1:0]             write_permission_setting,
  input wire logic [3:0]             operation_mode_setting,
  input wire logic [NUM_SLOTS*7-1:0] input_function_settings,
  input wire logic [NUM_SLOTS-1:0]   termIn,
  input wire logic [NUM_SLOTS-1:0]   netIn,
  input wire logic                   settingWriteRefused,
  input wire logic [1:0]             operation_source_setting,
  input wire logic [1:0]             speed_source_setting,
  input wire logic                   opNetActive,
  input wire logic                   spdNetActive,
  input wire logic                   thermal_relay_in,
  input wire logic                   pid_valid_in,
  input wire logic                   brake_release_done_in,
  input wire logic                   output_stop_in,
  input wire logic                   drive_reset_in
);
  function automatic logic hit(input logic [NUM_SLOTS-1:0] v, input logic [6:0] c);
    hit = 1'b0;
    for (int i = 0; i < NUM_SLOTS; i++)
      hit |= v[i] && input_function_settings[7*i+:7] == c;
  endfunction
  logic swOff, refE, thT, pidE, brkE, stpE, rstT, stpI;
  always_comb
  begin
    swOff = hit('1, FN_SRC_SWITCH) && !hit(termIn, FN_SRC_SWITCH);
    refE = !driveStopped && write_permission_setting != WR_PERM_RUN;
    thT = hit(termIn, FN_THERMAL);
    pidE = spdNetActive ? hit(netIn, FN_PID_VALID) : hit(termIn, FN_PID_VALID);
    brkE = opNetActive ? hit(netIn, FN_BRAKE_DONE) : hit(termIn, FN_BRAKE_DONE);
    stpE = hit(termIn, FN_OUTPUT_STOP) | (opNetActive & hit(netIn, FN_OUTPUT_STOP));
    rstT = hit(termIn, FN_DRIVE_RESET);
    stpI = hit(termIn, FN_OUTPUT_STOP) && !hit('1, FN_PANEL_INTLK);
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_refuse;
    clkEn && settingWrite |=> settingWriteRefused == $past(refE);
  endproperty
  a_refuse: assert property (p_refuse) else $error("write refusal wrong");
  property p_hold;
    clkEn && !driveStopped |=> $stable(opNetActive) && $stable(spdNetActive)
      && $stable(operation_source_setting) && $stable(speed_source_setting);
  endproperty
  a_hold: assert property (p_hold) else $error("source changed while running");
  property p_sel;
    (clkEn && driveStopped && !settingWrite && $stable(termIn)
      && $stable(input_function_settings))[*3]
    |=> opNetActive == (operation_source_setting == OP_SRC_NET && !$past(swOff))
      && spdNetActive == (speed_source_setting == SPD_SRC_NET && !$past(swOff));
  endproperty
  a_sel: assert property (p_sel) else $error("effective source wrong");
  property p_thermal;
    clkEn |=> thermal_relay_in == $past(thT);
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal input wrong");
  property p_pid;
    clkEn |=> pid_valid_in == $past(pidE);
  endproperty
  a_pid: assert property (p_pid) else $error("pid valid route wrong");
  property p_brake;
    clkEn |=> brake_release_done_in == $past(brkE);
  endproperty
  a_brake: assert property (p_brake) else $error("brake done route wrong");
  property p_stop;
    clkEn && operation_mode_setting != OP_MODE_INTLK |=> output_stop_in == $past(stpE);
  endproperty
  a_stop: assert property (p_stop) else $error("output stop route wrong");
  property p_nreset;
    (clkEn && driveStopped && swOff)[*3] |=> drive_reset_in == $past(rstT);
  endproperty
  a_nreset: assert property (p_nreset) else $error("network reset not ignored");
  property p_intlk;
    clkEn && operation_mode_setting == OP_MODE_INTLK |=> output_stop_in == $past(stpI);
  endproperty
  a_intlk: assert property (p_intlk) else $error("panel interlock stop wrong");
  property p_freeze;
    !clkEn |=> $stable(opNetActive) && $stable(spdNetActive)
      && $stable(operation_source_setting) && $stable(thermal_relay_in)
      && $stable(output_stop_in) && $stable(settingWriteRefused);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule
bind ncs_source_select ncs_checker u_chk (.clk_sys, .reset, .clkEn, .driveStopped,
  .settingWrite, .write_permission_setting, .operation_mode_setting,
  .input_function_settings, .termIn, .netIn, .settingWriteRefused,
  .operation_source_setting, .speed_source_setting, .opNetActive, .spdNetActive,
  .thermal_relay_in, .pid_valid_in, .brake_release_done_in, .output_stop_in,
  .drive_reset_in);
`default_nettype wire

// file: ncs_far_model.sv
// far side model: terminal wiring and network host levels
`timescale 1ns/1ps
`default_nettype none
module ncs_far_model
  import ncs_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic [NUM_SLOTS-1:0] termReq,
  input  wire logic [NUM_SLOTS-1:0] netReq,
  input  wire logic                 resetReq,
  output var logic  [NUM_SLOTS-1:0] termIn,
  output var logic  [NUM_SLOTS-1:0] netIn,
  output var logic                  netResetReq
);
  initial
  begin
    termIn = '0;
    netIn = '0;
    netResetReq = 1'b0;
  end
  // levels move on the falling edge, clear of sampling
  always @(negedge clk_sys)
  begin
    termIn <= termReq;
    netIn <= netReq;
    netResetReq <= resetReq;
  end
endmodule
`default_nettype wire

// file: ncs_pkg.sv
// constants and types for the network command source selector
package ncs_pkg;
  // operation source setting decode
  localparam logic [1:0] OP_SRC_NET      = 2'h0;
  localparam logic [1:0] OP_SRC_EXT      = 2'h1;
  // speed source setting decode
  localparam logic [1:0] SPD_SRC_NET     = 2'h0;
  localparam logic [1:0] SPD_SRC_EXT1    = 2'h1;
  localparam logic [1:0] SPD_SRC_EXT2    = 2'h2;
  // write permission value allowing writes while running
  localparam logic [1:0] WR_PERM_RUN     = 2'h2;
  // operation mode value with panel interlock
  localparam logic [3:0] OP_MODE_INTLK   = 4'h7;
  // input function codes
  localparam logic [6:0] FN_THERMAL      = 7'h07;
  localparam logic [6:0] FN_FIFTEEN_SPD  = 7'h08;
  localparam logic [6:0] FN_RUN_ENABLE   = 7'h0a;
  localparam logic [6:0] FN_PANEL_INTLK  = 7'h0c;
  localparam logic [6:0] FN_PID_VALID    = 7'h0e;
  localparam logic [6:0] FN_BRAKE_DONE   = 7'h0f;
  localparam logic [6:0] FN_PANEL_EXT    = 7'h10;
  localparam logic [6:0] FN_VF_SWITCH    = 7'h12;
  localparam logic [6:0] FN_OUTPUT_STOP  = 7'h18;
  localparam logic [6:0] FN_FWD_RUN      = 7'h3c;
  localparam logic [6:0] FN_REV_RUN      = 7'h3d;
  localparam logic [6:0] FN_DRIVE_RESET  = 7'h3e;
  localparam logic [6:0] FN_PANEL_NET    = 7'h41;
  localparam logic [6:0] FN_EXT_NET      = 7'h42;
  localparam logic [6:0] FN_SRC_SWITCH   = 7'h43;
  // number of input function setting slots
  localparam int         NUM_SLOTS       = 7;
  // reset values of latched sources and settings
  localparam logic       RST_OP_NET      = 1'b0;
  localparam logic       RST_SPD_NET     = 1'b0;
  localparam logic [1:0] RST_OP_SETTING  = 2'h1;
  localparam logic [1:0] RST_SPD_SETTING = 2'h1;

  // routing of one function
  typedef enum logic [1:0]
  {
    NCS_ROUTE_NONE = 2'b00,
    NCS_ROUTE_TERM = 2'b01,
    NCS_ROUTE_NET  = 2'b10,
    NCS_ROUTE_BOTH = 2'b11
  } ncs_route_t;

  // setting update state
  typedef enum logic [0:0]
  {
    NCS_ST_IDLE    = 1'b0,
    NCS_ST_PENDING = 1'b1
  } ncs_state_t;
endpackage

// file: ncs_route_if.sv
// interface carrying the latched sources and the interlock mode and assignment to the route lookup
`timescale 1ns/1ps
`default_nettype none
interface ncs_route_if;
  import ncs_pkg::*;
  logic       opNet;
  logic       spdNet;
  logic       intlkMode;
  logic       intlkAssigned;
  modport src
  (
    output opNet,
    output spdNet,
    output intlkMode,
    output intlkAssigned
  );
  modport dst
  (
    input opNet,
    input spdNet,
    input intlkMode,
    input intlkAssigned
  );
endinterface
`default_nettype wire

// file: ncs_route_lookup.sv
// route lookup for one input function code
`timescale 1ns/1ps
`default_nettype none
module ncs_route_lookup
  import ncs_pkg::*;
(
  input wire logic [6:0] funcCode,
  ncs_route_if.dst       src,
  output ncs_route_t     route
);
  always_comb
  begin
    route = NCS_ROUTE_TERM;
    case (funcCode)
      FN_THERMAL:
        route = NCS_ROUTE_TERM;
      FN_RUN_ENABLE, FN_PANEL_INTLK, FN_DRIVE_RESET, FN_PANEL_EXT, FN_PANEL_NET, FN_EXT_NET,
      FN_SRC_SWITCH:
        route = NCS_ROUTE_TERM;
      FN_PID_VALID, FN_FIFTEEN_SPD:
        route = src.spdNet ? NCS_ROUTE_NET : NCS_ROUTE_TERM;
      FN_BRAKE_DONE, FN_VF_SWITCH, FN_FWD_RUN, FN_REV_RUN:
        route = src.opNet ? NCS_ROUTE_NET : NCS_ROUTE_TERM;
      FN_OUTPUT_STOP:
      begin
        if (src.intlkMode)
          route = src.intlkAssigned ? NCS_ROUTE_NONE : NCS_ROUTE_TERM;
        else
          route = src.opNet ? NCS_ROUTE_BOTH : NCS_ROUTE_TERM;
      end
      default:
        route = NCS_ROUTE_NONE;
    endcase
  end
endmodule
`default_nettype wire

// file: ncs_source_select.sv
// network mode command source selector top level
`timescale 1ns/1ps
`default_nettype none
module ncs_source_select
  import ncs_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  input  wire logic                 clkEn,
  input  wire logic                 driveStopped,
  input  wire logic                 settingWrite,
  input  wire logic [1:0]           operationSourceWr,
  input  wire logic [1:0]           speedSourceWr,
  input  wire logic [1:0]           write_permission_setting,
  input  wire logic [3:0]           operation_mode_setting,
  input  wire logic [NUM_SLOTS*7-1:0] input_function_settings,
  input  wire logic [NUM_SLOTS-1:0] termIn,
  input  wire logic [NUM_SLOTS-1:0] netIn,
  input  wire logic                 netResetReq,
  output logic                      settingWriteRefused,
  output logic [1:0]                operation_source_setting,
  output logic [1:0]                speed_source_setting,
  output logic                      opNetActive,
  output logic                      spdNetActive,
  output logic                      spdTermActive,
  output logic [NUM_SLOTS-1:0]      funcActive,
  output logic                      source_switchover_in,
  output logic                      thermal_relay_in,
  output logic                      run_enable_in,
  output logic                      pu_external_interlock_in,
  output logic                      drive_reset_in,
  output logic                      pid_valid_in,
  output logic                      fifteen_speed_sel_in,
  output logic                      brake_release_done_in,
  output logic                      vf_switch_in,
  output logic                      output_stop_in,
  output logic                      fwdRunIn,
  output logic                      revRunIn,
  output logic                      panel_net_switch_in,
  output logic                      ext_net_switch_in,
  output logic                      panel_ext_switch_in
);
  // settings and pending state
  logic [1:0]  opSetting_q;
  logic [1:0]  opSetting_d;
  logic [1:0]  spdSetting_q;
  logic [1:0]  spdSetting_d;
  logic [1:0]  opPend_q;
  logic [1:0]  opPend_d;
  logic [1:0]  spdPend_q;
  logic [1:0]  spdPend_d;
  ncs_state_t  state_q;
  ncs_state_t  state_d;
  logic        refused_q;
  logic        refused_d;
  // latched effective sources
  logic        opNet_q;
  logic        opNet_d;
  logic        spdNet_q;
  logic        spdNet_d;
  // switchover and interlock assignments, switchover level
  logic        swAssigned;
  logic        swLevel;
  logic        intlkAssigned;
  logic        network_source;
  // routed outputs
  logic [NUM_SLOTS-1:0] active_d;
  logic [NUM_SLOTS-1:0] active_q;
  ncs_route_t           route [NUM_SLOTS];

  ncs_route_if routeBus ();

  // find switchover and interlock assignments
  always_comb
  begin
    swAssigned    = 1'b0;
    swLevel       = 1'b0;
    intlkAssigned = 1'b0;
    for (int i = 0; i < NUM_SLOTS; i++)
    begin
      if (input_function_settings[i*7 +: 7] == FN_SRC_SWITCH)
      begin
        swAssigned = 1'b1;
        swLevel    = swLevel | termIn[i];
      end
      if (input_function_settings[i*7 +: 7] == FN_PANEL_INTLK)
        intlkAssigned = 1'b1;
    end
  end

  // setting writes and pending application
  always_comb
  begin
    opSetting_d  = opSetting_q;
    spdSetting_d = spdSetting_q;
    opPend_d     = opPend_q;
    spdPend_d    = spdPend_q;
    state_d      = state_q;
    refused_d    = 1'b0;
    case (state_q)
      NCS_ST_IDLE:
      begin
        if (settingWrite)
        begin
          if (driveStopped)
          begin
            opSetting_d  = operationSourceWr;
            spdSetting_d = speedSourceWr;
          end
          else if (write_permission_setting == WR_PERM_RUN)
          begin
            opPend_d = operationSourceWr;
            spdPend_d = speedSourceWr;
            state_d  = NCS_ST_PENDING;
          end
          else
            refused_d = 1'b1;
        end
      end
      NCS_ST_PENDING:
      begin
        if (settingWrite && (driveStopped || write_permission_setting == WR_PERM_RUN))
        begin
          opPend_d  = operationSourceWr;
          spdPend_d = speedSourceWr;
        end
        else if (settingWrite)
          refused_d = 1'b1;
        if (driveStopped)
        begin
          opSetting_d  = settingWrite ? operationSourceWr : opPend_q;
          spdSetting_d = settingWrite ? speedSourceWr : spdPend_q;
          state_d      = NCS_ST_IDLE;
        end
      end
      default:
        state_d = NCS_ST_IDLE;
    endcase
  end

  // effective source decision, loaded only while stopped
  always_comb
  begin
    opNet_d  = opNet_q;
    spdNet_d = spdNet_q;
    if (driveStopped)
    begin
      if (swAssigned && !swLevel)
      begin
        opNet_d  = 1'b0;
        spdNet_d = 1'b0;
      end
      else
      begin
        opNet_d  = (opSetting_d == OP_SRC_NET);
        spdNet_d = (spdSetting_d == SPD_SRC_NET);
      end
    end
  end

  assign network_source = ~(swAssigned & ~swLevel);

  assign routeBus.opNet         = opNet_q;
  assign routeBus.spdNet        = spdNet_q;
  assign routeBus.intlkMode     = (operation_mode_setting == OP_MODE_INTLK);
  assign routeBus.intlkAssigned = intlkAssigned;

  // per slot routing
  for (genvar g = 0; g < NUM_SLOTS; g++)
  begin : gSlot
    ncs_route_lookup uLookup
    (
      .funcCode (input_function_settings[g*7 +: 7]),
      .src      (routeBus),
      .route    (route[g])
    );
  end

  always_comb
  begin
    for (int i = 0; i < NUM_SLOTS; i++)
    begin
      case (route[i])
        NCS_ROUTE_TERM: active_d[i] = termIn[i];
        NCS_ROUTE_NET:  active_d[i] = netIn[i];
        NCS_ROUTE_BOTH: active_d[i] = termIn[i] | netIn[i];
        NCS_ROUTE_NONE: active_d[i] = 1'b0;
        default:        active_d[i] = 1'b0;
      endcase
    end
  end

  // per function decoded outputs
  logic [14:0] fn_d;
  logic [14:0] fn_q;
  always_comb
  begin
    fn_d = '0;
    for (int i = 0; i < NUM_SLOTS; i++)
    begin
      case (input_function_settings[i*7 +: 7])
        FN_SRC_SWITCH:  fn_d[0]  = fn_d[0]  | active_d[i];
        FN_THERMAL:     fn_d[1]  = fn_d[1]  | active_d[i];
        FN_RUN_ENABLE:  fn_d[2]  = fn_d[2]  | active_d[i];
        FN_PANEL_INTLK: fn_d[3]  = fn_d[3]  | active_d[i];
        FN_DRIVE_RESET: fn_d[4]  = fn_d[4]  | active_d[i];
        FN_PID_VALID:   fn_d[5]  = fn_d[5]  | active_d[i];
        FN_FIFTEEN_SPD: fn_d[6]  = fn_d[6]  | active_d[i];
        FN_BRAKE_DONE:  fn_d[7]  = fn_d[7]  | active_d[i];
        FN_VF_SWITCH:   fn_d[8]  = fn_d[8]  | active_d[i];
        FN_OUTPUT_STOP: fn_d[9]  = fn_d[9]  | active_d[i];
        FN_FWD_RUN:     fn_d[10] = fn_d[10] | active_d[i];
        FN_REV_RUN:     fn_d[11] = fn_d[11] | active_d[i];
        FN_PANEL_NET:   fn_d[12] = fn_d[12] | active_d[i];
        FN_EXT_NET:     fn_d[13] = fn_d[13] | active_d[i];
        FN_PANEL_EXT:   fn_d[14] = fn_d[14] | active_d[i];
        default:        fn_d = fn_d;
      endcase
    end
    // network reset only while the switchover allows network
    fn_d[4] = fn_d[4] | (netResetReq & network_source);
  end

  // settings registers
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      opSetting_q  <= RST_OP_SETTING;
      spdSetting_q <= RST_SPD_SETTING;
      opPend_q     <= RST_OP_SETTING;
      spdPend_q    <= RST_SPD_SETTING;
      state_q      <= NCS_ST_IDLE;
      refused_q    <= 1'b0;
    end
    else if (clkEn)
    begin
      opSetting_q  <= opSetting_d;
      spdSetting_q <= spdSetting_d;
      opPend_q     <= opPend_d;
      spdPend_q    <= spdPend_d;
      state_q      <= state_d;
      refused_q    <= refused_d;
    end
  end

  // source and routed output registers
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      opNet_q      <= RST_OP_NET;
      spdNet_q     <= RST_SPD_NET;
      active_q     <= '0;
      fn_q         <= '0;
    end
    else if (clkEn)
    begin
      opNet_q      <= opNet_d;
      spdNet_q     <= spdNet_d;
      active_q     <= active_d;
      fn_q         <= fn_d;
    end
  end

  assign settingWriteRefused      = refused_q;
  assign operation_source_setting = opSetting_q;
  assign speed_source_setting     = spdSetting_q;
  assign opNetActive              = opNet_q;
  assign spdNetActive             = spdNet_q;
  assign spdTermActive            = ~spdNet_q;
  assign funcActive               = active_q;
  assign source_switchover_in     = fn_q[0];
  assign thermal_relay_in         = fn_q[1];
  assign run_enable_in            = fn_q[2];
  assign pu_external_interlock_in = fn_q[3];
  assign drive_reset_in           = fn_q[4];
  assign pid_valid_in             = fn_q[5];
  assign fifteen_speed_sel_in     = fn_q[6];
  assign brake_release_done_in    = fn_q[7];
  assign vf_switch_in             = fn_q[8];
  assign output_stop_in           = fn_q[9];
  assign fwdRunIn                 = fn_q[10];
  assign revRunIn                 = fn_q[11];
  assign panel_net_switch_in      = fn_q[12];
  assign ext_net_switch_in        = fn_q[13];
  assign panel_ext_switch_in      = fn_q[14];
endmodule
`default_nettype wire

// file: ncs_source_select_tb_top.sv
// testbench for the command source selector
`timescale 1ns/1ps
`default_nettype none
module ncs_source_select_tb_top
  import ncs_pkg::*;
  ;
  logic                   clk_sys, reset, driveStopped, settingWrite, rReq, netResetReq;
  logic                   refused, opNet, spdNet, thermal, runEn, pid, brake, stopOut, rstOut;
  logic                   eo, es, sw;
  logic                   clkEn, spdTerm, swOut, puIntlk, fifteen, vf, fwd, rev;
  logic                   panelNet, extNet, panelExt;
  logic [1:0]             opWr, spdWr, perm, opSet, spdSet;
  logic [3:0]             mode;
  logic [5:0]             ex;
  logic [NUM_SLOTS-1:0]   tReq, nReq, termIn, netIn, fAct, exA;
  logic [NUM_SLOTS*7-1:0] funcSet;
  int                     errors, checks_done, seed;
  ncs_far_model u_far (.clk_sys, .termReq(tReq), .netReq(nReq), .resetReq(rReq), .termIn,
    .netIn, .netResetReq);
  ncs_source_select u_dut (.clk_sys, .reset, .clkEn, .driveStopped, .settingWrite,
    .operationSourceWr(opWr), .speedSourceWr(spdWr), .write_permission_setting(perm),
    .operation_mode_setting(mode), .input_function_settings(funcSet), .termIn, .netIn,
    .netResetReq, .settingWriteRefused(refused), .operation_source_setting(opSet),
    .speed_source_setting(spdSet), .opNetActive(opNet), .spdNetActive(spdNet),
    .spdTermActive(spdTerm), .funcActive(fAct), .source_switchover_in(swOut),
    .thermal_relay_in(thermal), .run_enable_in(runEn), .pu_external_interlock_in(puIntlk),
    .drive_reset_in(rstOut), .pid_valid_in(pid), .fifteen_speed_sel_in(fifteen),
    .brake_release_done_in(brake), .vf_switch_in(vf), .output_stop_in(stopOut), .fwdRunIn(fwd),
    .revRunIn(rev), .panel_net_switch_in(panelNet), .ext_net_switch_in(extNet),
    .panel_ext_switch_in(panelExt));
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // expected function levels for slots 0 to 5
  function automatic logic [5:0] route(input logic o, input logic s, input logic [6:0] t,
    input logic [6:0] n, input logic r, input logic w);
    route = {t[0], t[1], s ? n[2] : t[2], o ? n[3] : t[3], t[4] | (o & n[4]), t[5] | (w & r)};
  endfunction
  // expected levels of the second function sets in panel interlock mode
  function automatic logic [8:0] route2(input logic c, input logic o, input logic [6:0] t,
    input logic [6:0] n);
    route2 = {!c & t[6], !c & t[5], !c & t[4], c & t[6], o ? n[3] : t[3], o ? n[2] : t[2],
      c & (o ? n[4] : t[4]), o ? n[1] : t[1], !c & t[0]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cyc;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [1:0] o, input logic [1:0] s);
    @(negedge clk_sys);
    settingWrite = 1'b1;
    opWr = o;
    spdWr = s;
    @(negedge clk_sys);
    settingWrite = 1'b0;
  endtask
  initial
  begin
    #50us;
    errors++;
    end_of_test();
  end
  initial
  begin
    seed = 70983;
    errors = 0;
    checks_done = 0;
    reset = 1'b1;
    clkEn = 1'b1;
    driveStopped = 1'b1;
    settingWrite = 1'b0;
    opWr = 2'h0;
    spdWr = 2'h0;
    perm = 2'h0;
    mode = 4'h0;
    tReq = 7'h00;
    nReq = 7'h00;
    rReq = 1'b0;
    funcSet = {FN_SRC_SWITCH, FN_DRIVE_RESET, FN_OUTPUT_STOP, FN_BRAKE_DONE, FN_PID_VALID,
      FN_RUN_ENABLE, FN_THERMAL};
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    cyc();
    chk({opSet, spdSet}, {RST_OP_SETTING, RST_SPD_SETTING});
    // every source pair, switchover off then on
    for (int p = 0; p < 12; p++)
    begin
      sw = p >= 6;
      tReq = {sw, 6'h00};
      wr(2'(p % 2), 2'(p / 2 % 3));
      repeat (4) cyc();
      eo = sw && p % 2 == 0;
      es = sw && p / 2 % 3 == 0;
      chk({opSet, spdSet}, {2'(p % 2), 2'(p / 2 % 3)});
      chk({opNet, spdNet}, {eo, es});
      for (int k = 0; k < 24; k++)
      begin
        cyc();
        if (k > 0)
        begin
          chk({thermal, runEn, pid, brake, stopOut, rstOut}, ex);
          chk({fAct, swOut, spdTerm}, {exA, sw, !es});
        end
        tReq = {sw, 6'($random(seed))};
        nReq = 7'($random(seed));
        rReq = 1'($random(seed));
        ex = route(eo, es, tReq, nReq, rReq, sw);
        exA = {tReq[6:5], ex[1], ex[2], ex[3], ex[4], ex[5]};
      end
    end
    // writes while running, applied at the next stop
    @(negedge clk_sys);
    driveStopped = 1'b0;
    perm = 2'h1;
    wr(OP_SRC_NET, SPD_SRC_NET);
    chk(refused, 1'b1);
    perm = WR_PERM_RUN;
    wr(OP_SRC_NET, SPD_SRC_NET);
    chk(refused, 1'b0);
    repeat (3) cyc();
    chk({opSet, spdSet, opNet, spdNet}, {OP_SRC_EXT, SPD_SRC_EXT2, 2'b00});
    @(negedge clk_sys);
    driveStopped = 1'b1;
    repeat (3) cyc();
    chk({opSet, spdSet, opNet, spdNet}, {OP_SRC_NET, SPD_SRC_NET, 2'b11});
    @(negedge clk_sys);
    driveStopped = 1'b0;
    tReq = 7'h00;
    repeat (4) cyc();
    chk({opNet, spdNet}, 2'b11);
    @(negedge clk_sys);
    driveStopped = 1'b1;
    repeat (3) cyc();
    chk({opNet, spdNet}, 2'b00);
    @(negedge clk_sys);
    funcSet[48:42] = 7'h00;
    repeat (4) cyc();
    chk({opNet, spdNet}, 2'b11);
    // remaining functions in panel interlock mode, network then terminal sources
    for (int q = 0; q < 4; q++)
    begin
      @(negedge clk_sys);
      mode = OP_MODE_INTLK;
      funcSet = q[0] ? {FN_PANEL_INTLK, 7'h7f, FN_FWD_RUN, FN_FIFTEEN_SPD, FN_VF_SWITCH,
        FN_REV_RUN, FN_OUTPUT_STOP} : {FN_PANEL_NET, FN_EXT_NET, FN_PANEL_EXT,
        FN_FIFTEEN_SPD, FN_VF_SWITCH, FN_REV_RUN, FN_OUTPUT_STOP};
      wr(2'(q / 2), 2'(q / 2));
      repeat (2) cyc();
      for (int k = 0; k < 16; k++)
      begin
        tReq = 7'($random(seed));
        nReq = 7'($random(seed));
        repeat (2) cyc();
        chk({panelNet, extNet, panelExt, puIntlk, fifteen, vf, fwd, rev, stopOut},
          route2(q[0], q < 2, tReq, nReq));
      end
    end
    // clock enable low holds every register
    exA = fAct;
    @(negedge clk_sys);
    clkEn = 1'b0;
    tReq = ~tReq;
    wr(OP_SRC_NET, SPD_SRC_NET);
    chk({opSet, spdSet, fAct}, {OP_SRC_EXT, SPD_SRC_EXT1, exA});
    clkEn = 1'b1;
    cyc();
    end_of_test();
  end
endmodule
`default_nettype wire
